// file: src/bgp_port.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Eight pins, each with latch and direction
// - Direction one turns the driver off
// - Direction zero drives pin from latch
// - Data reads give pins, writes load latch
// - Pins serve only as plain I/O
// - Every reset makes all pins inputs
// - Power-on and brown-out reload latch, master-clear and watchdog keep it
// - Set/clear/toggle writes read, modify, rewrite all bits
// - Input pins' levels overwrite their latch bits
// - Pins sampled at start, latch written end
module bgp_port
  import bgp_pkg::*;
#(
  parameter int unsigned NUM_PINS = NUM_PINS_DEF,
  parameter int unsigned ADDR_W   = ADDR_W_DEF
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  master_clear_reset,
  input  wire logic                  watchdog_reset,
  input  wire logic                  brown_out_reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output var  logic [APB_DATA_W-1:0] prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic [NUM_PINS-1:0]   pin_in,
  output var  logic [NUM_PINS-1:0]   pin_out,
  output var  logic [NUM_PINS-1:0]   pin_oe_n
);

  // Elaboration guard: one byte of port, address must reach the map
  if (NUM_PINS < 1 || NUM_PINS > 8 || ADDR_W < 7 || ADDR_W > 32) begin : g_chk
    $error("bgp_port: NUM_PINS must be 1..8 and ADDR_W 7..32");
  end

  // Whole state of the port apart from the latch bank
  typedef struct packed {
    bgp_phase_t            phase;     // Bus phase
    logic [NUM_PINS-1:0]   dir;       // One per pin, 1 = input
    logic [NUM_PINS-1:0]   pin_smp;   // Pin levels caught at start of transfer
    logic [APB_DATA_W-1:0] rdata;     // Read data held for the access phase
    logic                  ready;     // Access-phase completion
    logic                  slverr;    // Unmapped address answer
  } bgp_port_st_t;

  bgp_port_st_t st_q;                 // Registered state
  bgp_port_st_t st_d;                 // Next state

  logic                 setup_cyc;    // Setup phase of a transfer
  logic                 access_done;  // Access phase completing this edge
  logic                 soft_rst;     // Any synchronous reset source
  logic                 hit_dir;      // Decode: direction register
  logic                 hit_data;     // Decode: data/latch register
  logic                 hit_set;      // Decode: set-bits register
  logic                 hit_clr;      // Decode: clear-bits register
  logic                 hit_tog;      // Decode: toggle-bits register
  logic                 hit_lat;      // Decode: latch readback
  logic                 hit_any;      // Any mapped register
  logic [NUM_PINS-1:0]  wmask;        // Write data cut to the port width
  logic [NUM_PINS-1:0]  rmw_set;      // Sampled pins with mask bits set
  logic [NUM_PINS-1:0]  rmw_clr;      // Sampled pins with mask bits cleared
  logic [NUM_PINS-1:0]  rmw_tog;      // Sampled pins with mask bits flipped
  logic                 lat_wr;       // Latch bank write strobe
  logic [NUM_PINS-1:0]  lat_wdata;    // Full byte written back to the latch
  logic [NUM_PINS-1:0]  latch_q;      // Latch bank contents

  // Bus phases
  assign setup_cyc   = psel && !penable;
  assign access_done = psel && penable && st_q.ready;

  // Soft resets come from the core and arrive synchronous to pclk.
  // Brown-out is folded in here for the direction bits only; its effect
  // on the latch bank goes over a wire of its own
  assign soft_rst    = master_clear_reset || watchdog_reset || brown_out_reset;

  // Address decode against byte addresses
  // Full compare on every bit, so aliases of the map answer with an error
  // instead of touching a register
  assign hit_dir  = (paddr == ADDR_W'(ADDR_DIR));
  assign hit_data = (paddr == ADDR_W'(ADDR_DATA));
  assign hit_set  = (paddr == ADDR_W'(ADDR_SET));
  assign hit_clr  = (paddr == ADDR_W'(ADDR_CLR));
  assign hit_tog  = (paddr == ADDR_W'(ADDR_TOG));
  assign hit_lat  = (paddr == ADDR_W'(ADDR_LAT));
  assign hit_any  = hit_dir || hit_data || hit_set || hit_clr || hit_tog || hit_lat;

  assign wmask = pwdata[NUM_PINS-1:0];

  // Per-pin modify step; the source is the pin sample, never the latch,
  // so an input pin hands its own level into its latch bit
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign rmw_set[i] = st_q.pin_smp[i] | wmask[i];
    assign rmw_clr[i] = st_q.pin_smp[i] & ~wmask[i];
    assign rmw_tog[i] = st_q.pin_smp[i] ^ wmask[i];
  end

  // A write to the latch readback address falls through to no write: the
  // readback only lets software see what the pins will be driven from
  // Latch write: every data, set, clear or toggle write lands as one
  // full-width byte at the closing edge of the transfer
  always_comb begin
    lat_wr    = 1'b0;
    lat_wdata = latch_q;
    if (access_done && pwrite) begin
      if (hit_data) begin
        lat_wr    = 1'b1;
        lat_wdata = wmask;
      end else if (hit_set) begin
        lat_wr    = 1'b1;
        lat_wdata = rmw_set;
      end else if (hit_clr) begin
        lat_wr    = 1'b1;
        lat_wdata = rmw_clr;
      end else if (hit_tog) begin
        lat_wr    = 1'b1;
        lat_wdata = rmw_tog;
      end else begin
        lat_wr    = 1'b0;
      end
    end
  end

  // Next-state logic for bus slave and direction bits
  always_comb begin
    st_d       = st_q;
    st_d.ready = 1'b0;
    case (st_q.phase)
      BGP_IDLE: begin
        if (setup_cyc) begin
          st_d.phase = BGP_ACCESS;
        end
      end
      BGP_ACCESS: begin
        // Stay here while the master keeps a back-to-back setup coming
        st_d.phase = setup_cyc ? BGP_ACCESS : BGP_IDLE;
      end
      default: begin
        st_d.phase = BGP_IDLE;
      end
    endcase
    // Setup edge: catch pins and prepare the answer one cycle ahead
    if (setup_cyc) begin
      st_d.ready   = 1'b1;
      st_d.slverr  = !hit_any;
      st_d.pin_smp = pin_in;
      st_d.rdata   = '0;
      if (!pwrite) begin
        if (hit_data) begin
          st_d.rdata[NUM_PINS-1:0] = pin_in;
        end else if (hit_dir) begin
          st_d.rdata[NUM_PINS-1:0] = st_q.dir;
        end else if (hit_lat) begin
          st_d.rdata[NUM_PINS-1:0] = latch_q;
        end else begin
          st_d.rdata = '0;
        end
      end
    end
    // Direction write, with the soft resets winning over it
    if (soft_rst) begin
      st_d.dir = DIR_RST_VAL[NUM_PINS-1:0];
    end else if (access_done && pwrite && hit_dir) begin
      st_d.dir = wmask;
    end
  end

  // State register; power-on makes every pin an input
  // Nothing here waits on the latch, so after power-on no pin is driven
  // before software has chosen a direction for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.phase   <= BGP_IDLE;
      st_q.dir     <= DIR_RST_VAL[NUM_PINS-1:0];
      st_q.pin_smp <= '0;
      st_q.rdata   <= '0;
      st_q.ready   <= 1'b0;
      st_q.slverr  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Latch bank; master-clear and watchdog leave it alone
  bgp_latch #(
    .WIDTH (NUM_PINS)
  ) i_bgp_latch (
    .pclk     (pclk),
    .presetn  (presetn),
    .bor_load (brown_out_reset),
    .wr_en    (lat_wr),
    .wr_data  (lat_wdata),
    .latch_q  (latch_q)
  );

  // Pin drive: no peripheral mux, the latch goes straight out and the
  // direction bit alone gates the driver; a latch held while the pin
  // was an input shows up as soon as the direction bit clears
  assign pin_out  = latch_q;
  assign pin_oe_n = st_q.dir;

  // Bus outputs
  assign prdata  = st_q.rdata;
  assign pready  = st_q.ready;
  assign pslverr = st_q.slverr;

  // Named steps of a transfer. The checks below watch only what the port
  // drives; pin levels on the far side are taken as they come, since
  // board loading is outside this block
  sequence s_setup_rd(logic hit);
    psel && !penable && !pwrite && hit;
  endsequence

  sequence s_setup_rd_data;
    psel && !penable && !pwrite && hit_data;
  endsequence

  sequence s_wr_done(logic hit);
    access_done && pwrite && hit && !brown_out_reset;
  endsequence

  // Every soft reset returns all pins to input
  a_dir_soft_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    soft_rst |=> (pin_oe_n == DIR_RST_VAL[NUM_PINS-1:0]))
    else $error("direction not all ones after reset");

  // Direction write drives the enables from the next cycle on
  a_dir_write_oe: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && hit_dir && !soft_rst) |=>
      (pin_oe_n == $past(wmask)))
    else $error("output enable does not follow direction write");

  // A data read answers with pin levels caught at the setup edge
  a_read_pins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_rd_data |=> pready && (prdata[NUM_PINS-1:0] == $past(pin_in)))
    else $error("data read does not return sampled pins");

  // Plain data write loads the latch at the closing edge
  a_data_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_data) |=> (pin_out == $past(wmask)))
    else $error("latch not loaded by data write");

  // Set-bits write rewrites the whole byte from sampled pins
  a_rmw_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_set) |=> (pin_out == ($past(st_q.pin_smp) | $past(wmask))))
    else $error("set-bits write wrong");

  // Input pins' sampled levels replace their latch bits on a clear
  a_rmw_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_clr) |=> (pin_out == ($past(st_q.pin_smp) & ~$past(wmask))))
    else $error("clear-bits write wrong");

  // Brown-out reloads the latch
  a_bor_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    brown_out_reset |=> (pin_out == LATCH_RST_VAL[NUM_PINS-1:0]))
    else $error("brown-out did not reload latch");

  // Without a latch write or brown-out the latch holds, soft resets too
  a_latch_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!lat_wr && !brown_out_reset) |=> $stable(pin_out))
    else $error("latch changed without a write");

  // Answer comes one cycle after setup and lasts one cycle
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 (!pready || $past(setup_cyc)))
    else $error("pready timing wrong");

  // Toggle-bits write flips the sampled pins under the mask
  a_rmw_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_tog) |=> (pin_out == ($past(st_q.pin_smp) ^ $past(wmask))))
    else $error("toggle-bits write wrong");

  // Master-clear or watchdog alone leaves the latch as it was
  a_soft_keeps_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((master_clear_reset || watchdog_reset) && !brown_out_reset && !lat_wr) |=>
      $stable(pin_out))
    else $error("soft reset disturbed latch");

  // Latch readback answers with what the pins are driven from
  a_latch_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_rd(hit_lat) |=> (prdata[NUM_PINS-1:0] == $past(pin_out)))
    else $error("latch readback wrong");

  // Direction readback answers with the driver enables
  a_dir_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_rd(hit_dir) |=> (prdata[NUM_PINS-1:0] == $past(pin_oe_n)))
    else $error("direction readback wrong");

  // Direction bits move only on a direction write or a reset
  a_dir_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!soft_rst && !(access_done && pwrite && hit_dir)) |=> $stable(pin_oe_n))
    else $error("direction changed without a write");

  // The modify addresses hold nothing to read
  a_rmw_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_rd(hit_set || hit_clr || hit_tog) |=> (prdata == '0))
    else $error("modify address read not zero");

  // A read leaves both latch and direction alone
  a_read_no_effect: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_done && !pwrite && !soft_rst) |=> ($stable(pin_out) && $stable(pin_oe_n)))
    else $error("read changed port state");

  // No answer without a setup edge just before it
  a_ready_after_setup: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup_cyc))
    else $error("pready without setup");

  // Upper data bits of a pin read stay zero
  a_read_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_rd(hit_data) |=> (prdata[APB_DATA_W-1:NUM_PINS] == '0))
    else $error("pin read upper bits not zero");

endmodule // bgp_port

`default_nettype wire

// file: src/bgp_pkg.sv
// Shared constants for the eight-pin bidirectional port.
package bgp_pkg;

  // Port geometry
  localparam int unsigned NUM_PINS_DEF = 8;              // Pins in the port
  localparam int unsigned APB_DATA_W   = 32;             // APB data width
  localparam int unsigned ADDR_W_DEF   = 8;              // Default paddr width

  // Register indices as printed, byte address is four times the index
  localparam logic [7:0] REG_DIR_IDX   = 8'h12;          // pin_direction_reg
  localparam logic [7:0] REG_DATA_IDX  = 8'h13;          // pin_data_latch_reg
  localparam logic [7:0] REG_SET_IDX   = 8'h14;          // Read-modify-write: set bits
  localparam logic [7:0] REG_CLR_IDX   = 8'h15;          // Read-modify-write: clear bits
  localparam logic [7:0] REG_TOG_IDX   = 8'h16;          // Read-modify-write: toggle bits
  localparam logic [7:0] REG_LAT_IDX   = 8'h17;          // Latch readback

  // Byte addresses
  localparam logic [7:0] ADDR_DIR      = 8'(REG_DIR_IDX * 4);
  localparam logic [7:0] ADDR_DATA     = 8'(REG_DATA_IDX * 4);
  localparam logic [7:0] ADDR_SET      = 8'(REG_SET_IDX * 4);
  localparam logic [7:0] ADDR_CLR      = 8'(REG_CLR_IDX * 4);
  localparam logic [7:0] ADDR_TOG      = 8'(REG_TOG_IDX * 4);
  localparam logic [7:0] ADDR_LAT      = 8'(REG_LAT_IDX * 4);

  // Reset values
  localparam logic [7:0] DIR_RST_VAL   = 8'hff;          // All pins input
  localparam logic [7:0] LATCH_RST_VAL = 8'h00;          // Stand-in for an unknown latch

  // Bus phase of the slave
  typedef enum logic {
    BGP_IDLE,
    BGP_ACCESS
  } bgp_phase_t;

endpackage

// file: src/bgp_latch.sv
`timescale 1ns/100ps
`default_nettype none

// Output latch bank: survives master-clear and watchdog, reloads on power-on and brown-out
module bgp_latch
  import bgp_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_PINS_DEF
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             bor_load,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic [WIDTH-1:0] latch_q
);

  // Whole state of the bank
  typedef struct packed {
    logic [WIDTH-1:0] bits;           // Latched output levels
  } bgp_latch_st_t;

  bgp_latch_st_t st_q;                // Registered state
  bgp_latch_st_t st_d;                // Next state

  if (WIDTH < 1 || WIDTH > 8) begin : g_chk
    $error("bgp_latch: WIDTH must be 1..8");
  end

  // Brown-out reload beats a write in the same cycle
  always_comb begin
    st_d = st_q;
    if (bor_load) begin
      st_d.bits = LATCH_RST_VAL[WIDTH-1:0];
    end else if (wr_en) begin
      st_d.bits = wr_data;
    end
  end

  // Power-on gives a fixed value since a real unknown cannot be built
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.bits <= LATCH_RST_VAL[WIDTH-1:0];
    end else begin
      st_q <= st_d;
    end
  end

  assign latch_q = st_q.bits;

endmodule // bgp_latch

`default_nettype wire

// file: bench/bgp_board.sv
`timescale 1ns/100ps
`default_nettype none

// Board circuitry on the eight pins: external drivers where enabled, pull-ups elsewhere
module bgp_board (
  input  wire logic [7:0] pin_out,   // Device latch drive
  input  wire logic [7:0] pin_oe_n,  // Low where the device drives
  input  wire logic [7:0] ext_val,   // Level forced by the board
  input  wire logic [7:0] ext_en,    // Board drivers active
  output var  logic [7:0] pin_in     // Resolved pin levels
);
  // Device wins where it drives; the bench leaves board drivers enabled on those pins too
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'b1;        // Pull-up holds a released pin high
      end
    end
  end
endmodule // bgp_board
`default_nettype wire

// file: bench/test_bidir_gpio_port_8bit.sv
`timescale 1ns/100ps
`default_nettype none

module test_bidir_gpio_port_8bit;
  import bgp_pkg::*;
  logic        pclk, presetn, master_clear_reset, watchdog_reset, brown_out_reset;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, pin_in, pin_out, pin_oe_n, ext_val, ext_en;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  lat, dir, p;                                // Expected latch, direction, pins
  logic [7:0]  rmw_addr [3] = '{ADDR_SET, ADDR_CLR, ADDR_TOG};
  logic [7:0]  rmw_mask [3] = '{8'h40, 8'h01, 8'h0c};
  int          failures, comparisons;

  bgp_port i_bgp_port (.pclk(pclk), .presetn(presetn),
    .master_clear_reset(master_clear_reset), .watchdog_reset(watchdog_reset),
    .brown_out_reset(brown_out_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  bgp_board i_bgp_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  // Pin levels the board should show, from the expected latch and direction
  function automatic logic [7:0] pins_exp();
    return (((ext_val & ext_en) | ~ext_en) & dir) | (lat & ~dir);
  endfunction

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; pready is looked at mid-cycle, where it already stands
  // for the next rising edge, so the edge that launches it is never raced
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);                                         // Idle cycle before setup
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("unexpected pready: expected 1 seen %b", pready);
    end
    // Edge at which pready is sampled high; data stand until the next setup
    @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, well above the hundred or so cycles the tests need
  initial begin
    repeat (4000) @(posedge pclk);
    failures++;
    $display("unexpected watchdog: expected done seen hang");
    wrap_up();
  end

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {master_clear_reset, watchdog_reset, brown_out_reset} = 3'b000;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_val = 8'h3c;
    ext_en = 8'hff;
    failures = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then an unmapped access that must be refused without effect
    lat = LATCH_RST_VAL;
    dir = DIR_RST_VAL;
    check("pin_oe_n", 32'(pin_oe_n), 32'(dir));
    xfer(ADDR_DIR, 1'b0, 32'h0);
    check("dir", rd, 32'(dir));
    check("pslverr", 32'(err), 32'h0);
    xfer(ADDR_LAT, 1'b0, 32'h0);
    check("latch", rd, 32'(lat));
    xfer(8'h00, 1'b1, 32'h0);
    check("pslverr", 32'(err), 32'h1);
    xfer(ADDR_DIR, 1'b0, 32'h0);
    check("dir", rd, 32'(dir));
    $display("test reset done");
    // Latch written while all pins are inputs: pins keep board levels
    xfer(ADDR_DATA, 1'b1, 32'ha5);
    lat = 8'ha5;
    xfer(ADDR_DATA, 1'b0, 32'h0);
    check("pins", rd, 32'(pins_exp()));
    check("pin_oe_n", 32'(pin_oe_n), 32'hff);
    xfer(ADDR_LAT, 1'b0, 32'h0);
    check("latch", rd, 32'(lat));
    $display("test latch done");
    // High nibble turned to outputs: held latch appears there at once
    xfer(ADDR_DIR, 1'b1, 32'h0f);
    dir = 8'h0f;
    xfer(ADDR_DATA, 1'b0, 32'h0);
    check("pins", rd, 32'(pins_exp()));
    check("pin_oe_n", 32'(pin_oe_n), 32'(dir));
    check("pin_out", 32'(pin_out), 32'(lat));
    $display("test direction done");
    // Set, clear, toggle: source is the sampled pins, so input bits take pin level
    for (int i = 0; i < 3; i++) begin
      p = pins_exp();
      case (i)
        0: lat = p | rmw_mask[i];
        1: lat = p & ~rmw_mask[i];
        default: lat = p ^ rmw_mask[i];
      endcase
      xfer(rmw_addr[i], 1'b1, 32'(rmw_mask[i]));
      xfer(ADDR_LAT, 1'b0, 32'h0);
      check("rmw latch", rd, 32'(lat));
      xfer(rmw_addr[i], 1'b0, 32'h0);
      check("rmw read", rd, 32'h0);
    end
    $display("test rmw done");
    // Master-clear, watchdog, brown-out in turn
    for (int k = 0; k < 3; k++) begin
      xfer(ADDR_DATA, 1'b1, 32'h5a);                         // Latch first
      lat = 8'h5a;
      xfer(ADDR_DIR, 1'b1, 32'h0);
      @(posedge pclk);
      master_clear_reset <= (k == 0);
      watchdog_reset     <= (k == 1);
      brown_out_reset    <= (k == 2);
      @(posedge pclk);
      {master_clear_reset, watchdog_reset, brown_out_reset} <= 3'b000;
      dir = DIR_RST_VAL;
      if (k == 2) begin
        lat = LATCH_RST_VAL;
      end
      xfer(ADDR_DIR, 1'b0, 32'h0);
      check("dir", rd, 32'(dir));
      xfer(ADDR_LAT, 1'b0, 32'h0);
      check("latch", rd, 32'(lat));
    end
    $display("test soft resets done");
    wrap_up();
  end
endmodule // test_bidir_gpio_port_8bit
`default_nettype wire
